// file: hw/dmsvf_defs.svh
`ifndef DMSVF_DEFS_SVH
`define DMSVF_DEFS_SVH
`define DMSVF_SR_W 6
`define DMSVF_LOAD_PATTERN 6'h10
`define DMSVF_SR_OUT_POS 0
`define DMSVF_BA_EXTRA 2'h2
`define DMSVF_SOFT_WRITES 4'h7
`define DMSVF_SOFT_MATCH 4'h8
`define DMSVF_PORT_ADDR 16'hFCFC
`endif

// file: hw/dmsvf_pkg.sv
package dmsvf_pkg;
  typedef struct packed {
    logic access_valid;
    logic read;
    logic bus_granted;
    logic tristate_request;
    logic halt_n;
  } dmsvf_bus_t;
  typedef struct packed {
    logic clear_map_shifter;
    logic exec_reset;
    logic user_reset;
    logic port_strobe;
    logic nmi_from_module;
    logic nmi_vector_fetch;
    logic soft_vector_fetch;
    logic breakpoint_redirect_enable;
  } dmsvf_ctl_t;
  typedef enum logic [1:0] {LD_IDLE, LD_ARMED, LD_SETTLE} dmsvf_load_t;
endpackage

// file: hw/dmsvf_top.sv
`timescale 1ns/1ps
`include "dmsvf_defs.svh"
// Notes on behaviour
// - tristate map valid drivers on tristate or halt
// - shift tick comes from inverted phase-2
// - no shift ticks while granted or tristated
// - two extra suppressed ticks after bus grant
// - clear empties shifter and load logic
// - force exec map for redirected vectors
// - nmi redirected only when module raised it
// - read, seven writes, read flags soft interrupt
// - soft interrupt redirect needs breakpoint enable
// - soft counter on shift tick, stops on tristate
// - strobe arms load, one user data cycle
// - shifter high gives user, low exec
// - exec reset clears, user reset sets serial
module dmsvf_top #(
  parameter logic [`DMSVF_SR_W-1:0] LOAD_PATTERN = `DMSVF_LOAD_PATTERN
) (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PHI2_IN,
  input wire dmsvf_pkg::dmsvf_bus_t BUS_IN,
  input wire dmsvf_pkg::dmsvf_ctl_t CTL_IN,
  output logic USER_MAP_VALID_OUT,
  output logic USER_MAP_VALID_OE_N_OUT,
  output logic EXEC_MAP_VALID_OUT,
  output logic EXEC_MAP_VALID_OE_N_OUT,
  output logic SHIFT_TICK_OUT,
  output logic SHIFTER_MAP_OUTPUT_OUT,
  output logic SOFT_INT_DETECTED_OUT,
  output logic FORCE_EXEC_MAP_OUT
);
  import dmsvf_pkg::*;

  // pin synchronisers; third phase-2 stage only feeds the edge detect
  dmsvf_bus_t bus_meta_reg, bus_reg;
  dmsvf_ctl_t ctl_meta_reg, ctl_reg;
  logic [2:0] phi2_reg;
  logic strobe_prev_reg;
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      bus_meta_reg <= '0;
      bus_reg <= '0;
      ctl_meta_reg <= '0;
      ctl_reg <= '0;
      phi2_reg <= 3'h0;
      strobe_prev_reg <= 1'b0;
    end
    else
    begin
      bus_meta_reg <= BUS_IN;
      bus_reg <= bus_meta_reg;
      ctl_meta_reg <= CTL_IN;
      ctl_reg <= ctl_meta_reg;
      phi2_reg <= {phi2_reg[1:0], PHI2_IN};
      strobe_prev_reg <= ctl_reg.port_strobe;
    end
  end

  logic phi2_fall;
  logic busy;
  logic shift_tick;
  logic strobe_rise;
  logic [1:0] ba_hold_reg;
  assign phi2_fall = phi2_reg[2] & ~phi2_reg[1];
  assign busy = bus_reg.bus_granted | bus_reg.tristate_request;
  assign shift_tick = phi2_fall & ~busy & (ba_hold_reg == 2'h0);
  assign strobe_rise = ctl_reg.port_strobe & ~strobe_prev_reg;

  // grant edges lag the shift clock, so two more ticks are dropped
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      ba_hold_reg <= 2'h0;
    else if (bus_reg.bus_granted)
      ba_hold_reg <= `DMSVF_BA_EXTRA;
    else if (phi2_fall && !bus_reg.tristate_request && ba_hold_reg != 2'h0)
      ba_hold_reg <= ba_hold_reg - 2'h1;
  end

  // map shifter and its load sequence
  logic [`DMSVF_SR_W-1:0] sr_reg;
  logic serial_reg;
  dmsvf_load_t load_state_reg;
  logic sr_out;
  assign sr_out = sr_reg[`DMSVF_SR_OUT_POS];
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      sr_reg <= '0;
      serial_reg <= 1'b0;
      load_state_reg <= LD_IDLE;
    end
    else if (ctl_reg.clear_map_shifter || ctl_reg.exec_reset)
    begin
      sr_reg <= '0;
      serial_reg <= 1'b0;
      load_state_reg <= LD_IDLE;
    end
    else if (ctl_reg.user_reset)
    begin
      serial_reg <= 1'b1;
      load_state_reg <= LD_IDLE;
    end
    else
    begin
      case (load_state_reg)
        LD_IDLE:
        begin
          // one-shot on the strobe edge so a long strobe loads once
          if (strobe_rise)
            load_state_reg <= LD_ARMED;
          else if (shift_tick)
            sr_reg <= {serial_reg, sr_reg[`DMSVF_SR_W-1:1]};
        end
        LD_ARMED:
        begin
          if (shift_tick)
          begin
            sr_reg <= LOAD_PATTERN;
            load_state_reg <= LD_SETTLE;
          end
        end
        LD_SETTLE:
        begin
          // shifting starts on the second tick after the load
          if (shift_tick)
            load_state_reg <= LD_IDLE;
        end
        default:
          load_state_reg <= LD_IDLE;
      endcase
    end
  end

  // soft interrupt cycle counter; tick already stops on tristate
  logic [3:0] soft_cnt_reg;
  logic soft_det_reg;
  logic soft_match;
  assign soft_match = shift_tick & (soft_cnt_reg == `DMSVF_SOFT_MATCH) & bus_reg.read;
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      soft_cnt_reg <= 4'h0;
      soft_det_reg <= 1'b0;
    end
    else if (ctl_reg.clear_map_shifter || ctl_reg.exec_reset)
    begin
      soft_cnt_reg <= 4'h0;
      // a match in the clearing cycle still sets the flag
      soft_det_reg <= soft_match;
    end
    else if (shift_tick && !bus_reg.tristate_request)
    begin
      if (soft_match)
      begin
        soft_det_reg <= 1'b1;
        soft_cnt_reg <= 4'h1;
      end
      else if (bus_reg.read)
        soft_cnt_reg <= 4'h1;
      else if (soft_cnt_reg != 4'h0 && soft_cnt_reg <= `DMSVF_SOFT_WRITES)
        soft_cnt_reg <= soft_cnt_reg + 4'h1;
      else
        soft_cnt_reg <= 4'h0;
    end
  end

  // registered map valids and drivers
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      USER_MAP_VALID_OUT <= 1'b0;
      EXEC_MAP_VALID_OUT <= 1'b0;
      USER_MAP_VALID_OE_N_OUT <= 1'b1;
      EXEC_MAP_VALID_OE_N_OUT <= 1'b1;
    end
    else
    begin
      USER_MAP_VALID_OUT <= bus_reg.access_valid & sr_out & ~FORCE_EXEC_MAP_OUT;
      EXEC_MAP_VALID_OUT <= bus_reg.access_valid & (~sr_out | FORCE_EXEC_MAP_OUT);
      USER_MAP_VALID_OE_N_OUT <= bus_reg.tristate_request | ~bus_reg.halt_n;
      EXEC_MAP_VALID_OE_N_OUT <= bus_reg.tristate_request | ~bus_reg.halt_n;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      SHIFT_TICK_OUT <= 1'b0;
      SHIFTER_MAP_OUTPUT_OUT <= 1'b0;
      SOFT_INT_DETECTED_OUT <= 1'b0;
      FORCE_EXEC_MAP_OUT <= 1'b0;
    end
    else
    begin
      SHIFT_TICK_OUT <= shift_tick;
      SHIFTER_MAP_OUTPUT_OUT <= sr_out;
      SOFT_INT_DETECTED_OUT <= soft_det_reg;
      FORCE_EXEC_MAP_OUT <= (ctl_reg.nmi_vector_fetch & ctl_reg.nmi_from_module)
        | (ctl_reg.soft_vector_fetch & soft_det_reg & ctl_reg.breakpoint_redirect_enable);
    end
  end

  a_tristate_drivers: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (bus_reg.tristate_request || !bus_reg.halt_n) |=> (USER_MAP_VALID_OE_N_OUT && EXEC_MAP_VALID_OE_N_OUT))
    else $error("map valid drivers not released");
  a_busy_no_tick: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    busy |=> !SHIFT_TICK_OUT)
    else $error("shift tick while bus busy");
  a_grant_extra: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    bus_reg.bus_granted |=> (ba_hold_reg == `DMSVF_BA_EXTRA) && !shift_tick)
    else $error("grant hold not loaded");
  a_clear_shifter: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (ctl_reg.clear_map_shifter || ctl_reg.exec_reset) |=> (sr_reg == '0) && !serial_reg && load_state_reg == LD_IDLE)
    else $error("shifter not cleared");
  a_load_pattern: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (load_state_reg == LD_ARMED && shift_tick && !ctl_reg.clear_map_shifter && !ctl_reg.exec_reset
      && !ctl_reg.user_reset) |=> (sr_reg == LOAD_PATTERN) && load_state_reg == LD_SETTLE)
    else $error("load pattern missing");
  a_valid_gated: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !bus_reg.access_valid |=> !USER_MAP_VALID_OUT && !EXEC_MAP_VALID_OUT)
    else $error("valid without access");
  a_user_select: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (bus_reg.access_valid && sr_out && !FORCE_EXEC_MAP_OUT) |=> USER_MAP_VALID_OUT && !EXEC_MAP_VALID_OUT)
    else $error("user map not selected");
  a_soft_match: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    soft_match |=> ##1 SOFT_INT_DETECTED_OUT)
    else $error("soft interrupt not flagged");
  a_nmi_foreign: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (!ctl_reg.nmi_from_module && !ctl_reg.soft_vector_fetch) |=> !FORCE_EXEC_MAP_OUT)
    else $error("foreign nmi forced to exec map");
  a_nmi_redirect: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (ctl_reg.nmi_vector_fetch && ctl_reg.nmi_from_module) |=> FORCE_EXEC_MAP_OUT)
    else $error("module nmi vector not forced");
  a_soft_redirect: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (ctl_reg.soft_vector_fetch && !ctl_reg.breakpoint_redirect_enable && !ctl_reg.nmi_vector_fetch)
      |=> !FORCE_EXEC_MAP_OUT)
    else $error("soft vector forced without enable");
  a_tristate_count: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (bus_reg.tristate_request && !ctl_reg.clear_map_shifter && !ctl_reg.exec_reset) |=> $stable(soft_cnt_reg))
    else $error("soft counter moved while tristated");
  a_user_reset: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (ctl_reg.user_reset && !ctl_reg.clear_map_shifter && !ctl_reg.exec_reset) |=> serial_reg)
    else $error("user reset did not set serial input");
endmodule

// file: verification/dmsvf_cpu_model.sv
`timescale 1ns/1ps
module dmsvf_cpu_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic av_in,
  input wire logic rd_in,
  output logic phi2_out,
  output logic av_out,
  output logic rd_out,
  output logic start_out
);
  logic [3:0] cnt_reg;
  // 8 clocks per phi2 level, well above the 3 the sync stage needs
  assign phi2_out = ~cnt_reg[3];
  assign start_out = cnt_reg == 4'hF;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= 4'h0;
      av_out <= 1'b0;
      rd_out <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 4'h1;
      if (start_out)
      begin
        av_out <= av_in;
        rd_out <= rd_in;
      end
    end
  end
endmodule

// file: verification/tb_dmsvf_top.sv
`timescale 1ns/1ps
module tb_dmsvf_top;
  import dmsvf_pkg::*;
  localparam logic [7:0] CT [6] = '{8'h03, 8'h02, 8'h04, 8'h0C, 8'h80, 8'h00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic n_av = 1'b0;
  logic n_rd = 1'b1;
  logic ts = 1'b0;
  logic gr = 1'b0;
  logic s_cur = 1'b0;
  logic hl = 1'b0;
  logic phi2, av, rd, start, uv, uoe, xv, xoe, tick, sh, det, frc, tk;
  logic [3:0] vv;
  logic [7:0] q[$];
  int failures = 0;
  int samples_checked = 0;
  dmsvf_ctl_t ctl = '0;
  dmsvf_bus_t bus;
  assign bus = {av, rd, gr, ts, ~hl};
  initial
    forever #2 clk = ~clk;
  dmsvf_cpu_model cpu (.clk_in(clk), .rst_n_in(rst_n), .av_in(n_av), .rd_in(n_rd), .phi2_out(phi2),
    .av_out(av), .rd_out(rd), .start_out(start));
  dmsvf_top DUT (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .PHI2_IN(phi2), .BUS_IN(bus), .CTL_IN(ctl),
    .USER_MAP_VALID_OUT(uv), .USER_MAP_VALID_OE_N_OUT(uoe), .EXEC_MAP_VALID_OUT(xv),
    .EXEC_MAP_VALID_OE_N_OUT(xoe), .SHIFT_TICK_OUT(tick), .SHIFTER_MAP_OUTPUT_OUT(sh),
    .SOFT_INT_DETECTED_OUT(det), .FORCE_EXEC_MAP_OUT(frc));
  task automatic end_sim;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus cycle; note = tick, user, exec, oe_n x2, shifter after tick, detected, force
  task automatic cyc(input logic a, r, t, g, k, sa, d, f);
    n_av <= a;
    n_rd <= r;
    @(posedge clk iff start);
    ts <= t;
    gr <= g;
    // a halted cpu grants its bus, so halt rides with grant
    hl <= g;
    q.push_back({k, a & s_cur & ~f, a & (~s_cur | f), t | g, t | g, sa, d, f});
    s_cur = sa;
  endtask
  // valids sampled mid-cycle before the tick lands, state near cycle end
  always @(posedge clk iff start)
  begin
    repeat (7) @(posedge clk);
    #1;
    vv = {uv, xv, uoe, xoe};
    tk = 1'b0;
    repeat (7)
    begin
      @(posedge clk);
      #1;
      tk = tk | tick;
    end
    if (q.size() > 0)
      chk({tk, vv, sh, det, frc}, q.pop_front());
  end
  initial
  begin
    void'($urandom(32'hE11F));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (16) cyc(1'($urandom), 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    $display("test random exec done");
    for (int i = 0; i < 4; i++)
      cyc(i == 3, 1'b1, 1'b0, i == 0, i == 3, 1'b0, 1'b0, 1'b0);
    $display("test grant done");
    cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    ctl.port_strobe <= 1'b1;
    for (int i = 6; i > 0; i--)
    begin
      cyc(i > 4 || i == 1, i != 1, 1'b0, 1'b0, 1'b1, i == 2, 1'b0, 1'b0);
      ctl.port_strobe <= 1'b0;
    end
    $display("test user store done");
    // tristate in mid-sequence must only pause the counter
    for (int i = 0; i < 10; i++)
      cyc(i != 4, i == 0 || i == 9, i == 4, 1'b0, i != 4, 1'b0, i == 9, 1'b0);
    $display("test soft detect done");
    for (int i = 0; i < 6; i++)
    begin
      cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, i < 4, i == 0 || i == 3);
      ctl <= CT[i];
    end
    $display("test force done");
    // user reset sets the serial input so ones shift in, exec reset empties it
    for (int i = 0; i < 10; i++)
    begin
      cyc(i != 8, 1'b1, 1'b0, 1'b0, 1'b1, i == 6 || i == 7, 1'b0, 1'b0);
      ctl <= (i == 0) ? 8'h20 : ((i == 8) ? 8'h40 : 8'h00);
    end
    $display("test reset modes done");
    wait (q.size() == 0);
    repeat (20) @(posedge clk);
    end_sim;
  end
  // about 50 bus cycles of 64 ns each; ample margin
  initial
  begin
    #40000;
    failures++;
    end_sim;
  end
endmodule
